// ==== shared/lhf_pkg.sv ====
package lhf_pkg;
  // widths and counts
  localparam int NUM_RELAY = 2;
  localparam int NUM_LED = 6;
  localparam int CNT_W = 8;
  localparam int MS_W = 16;
  localparam int LVL_W = 3;
  // clock and millisecond tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  // factory configuration after reset
  localparam logic FAILSAFE_EN_RST = 1'h0;
  localparam logic LED_EN_RST = 1'h1;
  localparam int LED_PERSIST_S = 1;
  localparam logic [MS_W-1:0] LED_PERSIST_MS_RST = MS_W'(LED_PERSIST_S * 1000);
  localparam logic [MS_W-1:0] HB_MS_RST = 16'h2710;
  localparam logic [CNT_W-1:0] MISS_LIMIT_RST = 8'h03;
  localparam logic [CNT_W-1:0] TIMEOUT_MULT_RST = 8'h01;
  localparam logic [NUM_RELAY-1:0] DEFAULT_STATE_RST = 2'h0;
  localparam logic [NUM_RELAY-1:0] ALERT_EN_RST = 2'h0;
  // test button hold to accept a configuration connection
  localparam int BTN_HOLD_S = 5;
  localparam logic [MS_W-1:0] BTN_HOLD_MS = MS_W'(BTN_HOLD_S * 1000);
  // heartbeat supervision states
  typedef enum logic [1:0] {HB_IDLE, HB_CHECK, HB_RETRY} lhf_hb_state_t;
  // configuration connection states
  typedef enum logic [1:0] {CFG_IDLE, CFG_WAIT, CFG_CONN} lhf_cfg_state_t;
endpackage : lhf_pkg

// ==== shared/lhf_timer_if.sv ====
`timescale 1ns/1ps
interface lhf_timer_if;
  logic                      tick;     // millisecond tick
  logic                      start;    // restart count from zero
  logic                      clear;    // abandon count
  logic [lhf_pkg::MS_W-1:0]  target;   // length in ms
  logic                      busy;     // counting
  logic                      expired;  // one-cycle pulse at end
  modport owner (output tick, start, clear, target, input busy, expired);
  modport timer (input tick, start, clear, target, output busy, expired);
endinterface : lhf_timer_if

// ==== verilog/lhf_prescale.sv ====
`timescale 1ns/1ps
module lhf_prescale #(
  parameter int TICK_CYCLES = lhf_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // one-cycle pulse every TICK_CYCLES clocks
  output logic      tick
);
  logic [31:0] div_q;  // cycle divider

  // free-running divider, tick registered
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q <= 32'h0;
      tick  <= 1'h0;
    end
    else if (div_q >= 32'(TICK_CYCLES - 1))
    begin
      div_q <= 32'h0;
      tick  <= 1'h1;
    end
    else
    begin
      div_q <= div_q + 32'h1;
      tick  <= 1'h0;
    end
  end
endmodule : lhf_prescale

// ==== verilog/lhf_hold_timer.sv ====
`timescale 1ns/1ps
module lhf_hold_timer (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  reset_n,
  // control and result
  lhf_timer_if.timer tIf
);
  logic [lhf_pkg::MS_W-1:0] count_q;  // ticks seen so far

  // start wins over clear so a restart is never lost
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q     <= '0;
      tIf.busy    <= 1'h0;
      tIf.expired <= 1'h0;
    end
    else
    begin
      tIf.expired <= 1'h0;
      if (tIf.start)
      begin
        count_q  <= '0;
        tIf.busy <= 1'h1;
      end
      else if (tIf.clear)
        tIf.busy <= 1'h0;
      else if (tIf.busy && tIf.tick)
      begin
        // a zero target ends at the first tick
        if ({1'b0, count_q} + 17'h1 >= {1'b0, tIf.target})
        begin
          tIf.busy    <= 1'h0;
          tIf.expired <= 1'h1;
        end
        else
          count_q <= count_q + 16'h1;
      end
    end
  end
endmodule : lhf_hold_timer

// ==== verilog/lhf_link_failsafe.sv ====
`timescale 1ns/1ps
module lhf_link_failsafe #(
  parameter int TICK_CYCLES = lhf_pkg::MS_CYCLES  // clocks per ms tick
) (
  // clock and reset
  input  wire logic                                      ref_clk,
  input  wire logic                                      reset_n,
  // radio link events
  input  wire logic                                      exchangeOk,
  input  wire logic                                      remoteValid,
  input  wire logic [lhf_pkg::NUM_RELAY-1:0]             remoteRelayInN,
  input  wire logic                                      checkDone,
  output logic                                           statusCheckReq,
  // configuration connection
  input  wire logic                                      cfgConnReq,
  input  wire logic                                      cfgDisconnect,
  input  wire logic                                      testButtonN,
  output logic                                           cfgConnected,
  // configuration values, taken on cfgLoad while connected
  input  wire logic                                      cfgLoad,
  input  wire logic [lhf_pkg::MS_W-1:0]                  cfgHbMs,
  input  wire logic [lhf_pkg::CNT_W-1:0]                 cfgMissLimit,
  input  wire logic                                      cfgFsEn,
  input  wire logic [lhf_pkg::NUM_RELAY-1:0]             cfgDefault,
  input  wire logic [lhf_pkg::NUM_RELAY-1:0]             cfgAlertEn,
  input  wire logic [lhf_pkg::NUM_RELAY-1:0][lhf_pkg::CNT_W-1:0] cfgTimeoutMult,
  input  wire logic                                      cfgLedEn,
  input  wire logic [lhf_pkg::MS_W-1:0]                  cfgLedMs,
  // signal strength
  input  wire logic                                      rssiValid,
  input  wire logic [lhf_pkg::LVL_W-1:0]                 rssiLevel,
  output logic [lhf_pkg::NUM_LED-1:0]                    ledOn,
  // outputs and status
  output logic [lhf_pkg::NUM_RELAY-1:0]                  relayOut,
  output logic                                           retrying,
  output logic                                           commLost,
  output logic [lhf_pkg::CNT_W-1:0]                      missCount,
  output logic                                           mismatch
);
  // stored configuration
  logic [lhf_pkg::MS_W-1:0]                  hbMs_q;
  logic [lhf_pkg::CNT_W-1:0]                 missLimit_q;
  logic                                      fsEn_q;
  logic [lhf_pkg::NUM_RELAY-1:0]             default_q;
  logic [lhf_pkg::NUM_RELAY-1:0]             alertEn_q;
  logic [lhf_pkg::NUM_RELAY-1:0][lhf_pkg::CNT_W-1:0] mult_q;
  logic                                      ledEn_q;
  logic [lhf_pkg::MS_W-1:0]                  ledMs_q;
  // supervision state
  lhf_pkg::lhf_hb_state_t                    hbState_q;
  lhf_pkg::lhf_cfg_state_t                   cfgState_q;
  logic [lhf_pkg::MS_W-1:0]                  hbCnt_q;    // ms in current interval
  logic [lhf_pkg::NUM_RELAY-1:0]             fsHit;      // relay at its timeout
  logic                                      msTick;
  logic                                      success;    // any good exchange
  logic                                      hbElapse;   // interval ran out
  logic                                      lost;

  lhf_timer_if ledIf ();
  lhf_timer_if btnIf ();

  // thermometer code: level n lights the bottom n LEDs, level 7 lights all six
  function automatic logic [lhf_pkg::NUM_LED-1:0] thermo(input logic [lhf_pkg::LVL_W-1:0] lvl);
    logic [lhf_pkg::NUM_LED-1:0] pat;
    pat = '0;
    for (int k = 0; k < lhf_pkg::NUM_LED; k++)
      pat[k] = (32'(lvl) > k);
    return pat;
  endfunction : thermo

  lhf_prescale #(.TICK_CYCLES(TICK_CYCLES)) uTick (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .tick    (msTick)
  );
  lhf_hold_timer uLedTmr (.ref_clk(ref_clk), .reset_n(reset_n), .tIf(ledIf.timer));
  lhf_hold_timer uBtnTmr (.ref_clk(ref_clk), .reset_n(reset_n), .tIf(btnIf.timer));

  // a completed status check counts as an exchange too
  assign success  = exchangeOk | checkDone;
  assign hbElapse = msTick && ({1'b0, hbCnt_q} + 17'h1 >= {1'b0, hbMs_q});
  assign lost     = (missCount >= missLimit_q);

  // configuration store, factory values at reset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hbMs_q      <= lhf_pkg::HB_MS_RST;
      missLimit_q <= lhf_pkg::MISS_LIMIT_RST;
      fsEn_q      <= lhf_pkg::FAILSAFE_EN_RST;
      default_q   <= lhf_pkg::DEFAULT_STATE_RST;
      alertEn_q   <= lhf_pkg::ALERT_EN_RST;
      mult_q      <= {lhf_pkg::NUM_RELAY{lhf_pkg::TIMEOUT_MULT_RST}};
      ledEn_q     <= lhf_pkg::LED_EN_RST;
      ledMs_q     <= lhf_pkg::LED_PERSIST_MS_RST;
    end
    else if (cfgLoad && cfgState_q == lhf_pkg::CFG_CONN)
    begin
      // only a confirmed connection may change settings
      hbMs_q      <= cfgHbMs;
      missLimit_q <= cfgMissLimit;
      fsEn_q      <= cfgFsEn;
      default_q   <= cfgDefault;
      alertEn_q   <= cfgAlertEn;
      mult_q      <= cfgTimeoutMult;
      ledEn_q     <= cfgLedEn;
      ledMs_q     <= cfgLedMs;
    end
  end

  // heartbeat interval timer in ms
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      hbCnt_q <= '0;
    else if (success || hbElapse)
      hbCnt_q <= '0;
    else if (msTick)
      hbCnt_q <= hbCnt_q + 16'h1;
  end

  // supervision machine: check, then retry each interval
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hbState_q      <= lhf_pkg::HB_IDLE;
      statusCheckReq <= 1'h0;
      missCount      <= '0;
    end
    else
    begin
      statusCheckReq <= 1'h0;
      if (success)
      begin
        // success beats a same-cycle elapse
        hbState_q <= lhf_pkg::HB_IDLE;
        missCount <= '0;
      end
      else if (hbElapse)
      begin
        statusCheckReq <= 1'h1;
        case (hbState_q)
          lhf_pkg::HB_IDLE: hbState_q <= lhf_pkg::HB_CHECK;
          default:
          begin
            hbState_q <= lhf_pkg::HB_RETRY;
            if (missCount != 8'hFF)
              missCount <= missCount + 8'h01;
          end
        endcase
      end
    end
  end

  // status flags straight from flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      retrying <= 1'h0;
      commLost <= 1'h0;
    end
    else
    begin
      retrying <= (hbState_q == lhf_pkg::HB_RETRY) && !success;
      commLost <= lost && !success;
    end
  end

  // per-relay timeout compare and output update
  genvar gi;
  generate
    for (gi = 0; gi < lhf_pkg::NUM_RELAY; gi++)
    begin : gRelay
      // zero multiple means never; alert relays trip at the miss limit
      assign fsHit[gi] = fsEn_q && (alertEn_q[gi] ? lost
                         : (mult_q[gi] != 8'h00 && missCount >= mult_q[gi]));

      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          relayOut[gi] <= 1'h0;
        else if (remoteValid)
          relayOut[gi] <= ~remoteRelayInN[gi];
        else if (fsHit[gi])
          relayOut[gi] <= default_q[gi];
        // otherwise hold through any outage
      end
    end
  endgenerate

  // output versus paired input disagreement, one-cycle pulse
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      mismatch <= 1'h0;
    else
      mismatch <= remoteValid && (relayOut != ~remoteRelayInN);
  end

  // signal-strength display with persistence
  assign ledIf.tick   = msTick;
  assign ledIf.target = ledMs_q;
  assign ledIf.start  = rssiValid && ledEn_q;
  assign ledIf.clear  = !ledEn_q;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ledOn <= '0;
    else if (ledIf.start)
      ledOn <= thermo(rssiLevel);
    else if (ledIf.expired || !ledEn_q)
      ledOn <= '0;
  end

  // configuration connection: hold button to confirm
  assign btnIf.tick   = msTick;
  assign btnIf.target = lhf_pkg::BTN_HOLD_MS;
  assign btnIf.start  = (cfgState_q == lhf_pkg::CFG_WAIT) && !testButtonN
                        && !btnIf.busy && !btnIf.expired;
  assign btnIf.clear  = testButtonN;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfgState_q <= lhf_pkg::CFG_IDLE;
    else if (cfgDisconnect)
      cfgState_q <= lhf_pkg::CFG_IDLE;
    else
    begin
      case (cfgState_q)
        lhf_pkg::CFG_IDLE: if (cfgConnReq) cfgState_q <= lhf_pkg::CFG_WAIT;
        lhf_pkg::CFG_WAIT: if (btnIf.expired) cfgState_q <= lhf_pkg::CFG_CONN;
        default: cfgState_q <= cfgState_q;
      endcase
    end
  end

  // connected flag from its own flop
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfgConnected <= 1'h0;
    else
      cfgConnected <= (cfgState_q == lhf_pkg::CFG_CONN) && !cfgDisconnect;
  end

  // checks
  property p_hbRestart;
    @(posedge ref_clk) disable iff (!reset_n) success |=> hbCnt_q == 16'h0;
  endproperty
  a_hbRestart: assert property (p_hbRestart) else $error("timer not restarted");

  property p_checkStart;
    @(posedge ref_clk) disable iff (!reset_n) (hbElapse && !success) |=> statusCheckReq;
  endproperty
  a_checkStart: assert property (p_checkStart) else $error("no status check");

  property p_mismatch;
    @(posedge ref_clk) disable iff (!reset_n)
      (remoteValid && relayOut[0] == remoteRelayInN[0]) |=> mismatch;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch missed");

  property p_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      (!remoteValid && !fsHit[0]) |=> $stable(relayOut[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("relay moved");

  property p_failsafe;
    @(posedge ref_clk) disable iff (!reset_n)
      (!remoteValid && fsHit[1]) |=> relayOut[1] == $past(default_q[1]);
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("default not driven");

  property p_factory;
    @(posedge ref_clk) disable iff (!reset_n) (!fsEn_q && !remoteValid) |=> $stable(relayOut);
  endproperty
  a_factory: assert property (p_factory) else $error("relay moved while disabled");

  property p_follow;
    @(posedge ref_clk) disable iff (!reset_n)
      remoteValid |=> relayOut == ~$past(remoteRelayInN);
  endproperty
  a_follow: assert property (p_follow) else $error("relay not following");

  property p_missClear;
    @(posedge ref_clk) disable iff (!reset_n) success |=> missCount == 8'h00 && !commLost;
  endproperty
  a_missClear: assert property (p_missClear) else $error("miss count kept");

  property p_led;
    @(posedge ref_clk) disable iff (!reset_n)
      (rssiValid && ledEn_q && rssiLevel != 3'h0) |=> ledOn[0];
  endproperty
  a_led: assert property (p_led) else $error("led not lit");

  property p_btn;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(cfgState_q == lhf_pkg::CFG_CONN) |-> !$past(testButtonN, 2);
  endproperty
  a_btn: assert property (p_btn) else $error("connect without hold");

  c_retry: cover property (@(posedge ref_clk) disable iff (!reset_n) retrying);
  c_fsTrip: cover property (@(posedge ref_clk) disable iff (!reset_n) fsHit[0] ##1 remoteValid);
  c_conn: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(cfgConnected));
  c_ledOff: cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(ledOn[0]));
endmodule : lhf_link_failsafe

// ==== bench/lhf_peer_model.sv ====
`timescale 1ns/1ps
// paired unit: answers checks, pushes input changes, can go silent
module lhf_peer_model (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  // bench controls
  input  wire logic                          silent,       // radio lost
  input  wire logic                          kick,         // periodic exchanges
  input  wire logic [7:0]                    answerDelay,  // check reply latency
  input  wire logic [lhf_pkg::NUM_RELAY-1:0] peerInN,      // peer relay inputs
  // link toward the block
  input  wire logic                          statusCheckReq,
  output logic                               exchangeOk,
  output logic                               checkDone,
  output logic                               remoteValid,
  output logic [lhf_pkg::NUM_RELAY-1:0]      remoteRelayInN
);
  logic [7:0]                    waitCnt;  // reply countdown
  logic                          pend;     // check outstanding
  logic [2:0]                    kickCnt;  // exchange spacing
  logic [lhf_pkg::NUM_RELAY-1:0] lastInN;  // change detect
  logic                          silentS;  // bench controls taken at the rising edge
  logic                          kickS;
  logic [7:0]                    delayS;
  logic [lhf_pkg::NUM_RELAY-1:0] inNS;
  // the bench moves its controls at the falling edge, so read them half a cycle later
  always @(posedge ref_clk)
  begin
    silentS <= silent;
    kickS   <= kick;
    delayS  <= answerDelay;
    inNS    <= peerInN;
  end
  // falling edge drive so the block samples settled values
  always @(negedge ref_clk or negedge reset_n)
  begin : drv
    logic snd;
    if (!reset_n)
    begin
      {exchangeOk, checkDone, remoteValid, pend, waitCnt, kickCnt} <= '0;
      lastInN        <= peerInN;
      remoteRelayInN <= ~peerInN;
    end
    else
    begin
      snd = 1'b0;
      exchangeOk <= kickS && (kickCnt == 3'h0);
      kickCnt    <= kickCnt + 3'h1;
      checkDone  <= 1'b0;
      // one check at a time: a repeat request while busy does not restart the reply
      if (statusCheckReq && !silentS && !pend)
      begin
        pend    <= 1'b1;
        waitCnt <= delayS;
      end
      else if (pend && waitCnt != 8'h00)
        waitCnt <= waitCnt - 8'h01;
      else if (pend)
      begin
        // reply carries our inputs so the far side can compare outputs
        pend      <= 1'b0;
        checkDone <= 1'b1;
        snd       = 1'b1;
      end
      // input change goes out at once unless the radio is down
      if (!silentS && inNS != lastInN)
        snd = 1'b1;
      lastInN        <= inNS;
      remoteValid    <= snd;
      // unqualified data flips so a stale value can never pass
      remoteRelayInN <= snd ? inNS : ~inNS;
    end
  end
endmodule : lhf_peer_model

// ==== bench/lhf_link_failsafe_test.sv ====
`timescale 1ns/1ps
module lhf_link_failsafe_test;
  localparam int TICK = 4;  // clocks per ms, keeps seconds short
  // clock, reset, link
  logic ref_clk, reset_n, exchangeOk, remoteValid, checkDone, statusCheckReq;
  logic [lhf_pkg::NUM_RELAY-1:0] remoteRelayInN, peerInN, relayOut, cfgDefault, cfgAlertEn;
  // configuration connection and values
  logic cfgConnReq, cfgDisconnect, testButtonN, cfgConnected, cfgLoad, cfgFsEn, cfgLedEn;
  logic [lhf_pkg::MS_W-1:0]  cfgHbMs, cfgLedMs;
  logic [lhf_pkg::CNT_W-1:0] cfgMissLimit, missCount;
  logic [lhf_pkg::NUM_RELAY-1:0][lhf_pkg::CNT_W-1:0] cfgTimeoutMult;
  // indicators and status
  logic rssiValid, retrying, commLost, mismatch, silent, kick, sawMis;
  logic [lhf_pkg::LVL_W-1:0]   rssiLevel;
  logic [lhf_pkg::NUM_LED-1:0] ledOn;
  logic [7:0]                  answerDelay;
  int err_count, compares, reqCount, k;

  lhf_link_failsafe #(.TICK_CYCLES(TICK)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .exchangeOk(exchangeOk), .remoteValid(remoteValid), .remoteRelayInN(remoteRelayInN),
    .checkDone(checkDone), .statusCheckReq(statusCheckReq), .cfgConnReq(cfgConnReq),
    .cfgDisconnect(cfgDisconnect), .testButtonN(testButtonN), .cfgConnected(cfgConnected),
    .cfgLoad(cfgLoad), .cfgHbMs(cfgHbMs), .cfgMissLimit(cfgMissLimit), .cfgFsEn(cfgFsEn),
    .cfgDefault(cfgDefault), .cfgAlertEn(cfgAlertEn), .cfgTimeoutMult(cfgTimeoutMult),
    .cfgLedEn(cfgLedEn), .cfgLedMs(cfgLedMs), .rssiValid(rssiValid), .rssiLevel(rssiLevel),
    .ledOn(ledOn), .relayOut(relayOut), .retrying(retrying), .commLost(commLost),
    .missCount(missCount), .mismatch(mismatch));

  lhf_peer_model peer (.ref_clk(ref_clk), .reset_n(reset_n), .silent(silent), .kick(kick),
    .answerDelay(answerDelay), .peerInN(peerInN), .statusCheckReq(statusCheckReq),
    .exchangeOk(exchangeOk), .checkDone(checkDone), .remoteValid(remoteValid),
    .remoteRelayInN(remoteRelayInN));

  // free-running 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // pulse watchers on the rising edge, where the old value is read
  always @(posedge ref_clk)
  begin
    if (statusCheckReq === 1'b1) reqCount++;
    if (mismatch === 1'b1) sawMis = 1'b1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // an exhausted wait ends the run at once
  task automatic bound(input bit hit);
    if (!hit)
    begin
      err_count++;
      summarize();
    end
  endtask : bound

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // levels 0 to 6, then the factory persistence of one second
  task automatic t_led();
    for (int lv = 0; lv <= 6; lv++)
    begin
      rssiLevel = lv[2:0];
      rssiValid = 1'b1;
      cyc(1);
      rssiValid = 1'b0;
      cyc(1);
      chk(ledOn, (32'h1 << lv) - 32'h1);
    end
    cyc(1000 * TICK - 40);
    chk(ledOn, 6'h3F);
    for (k = 0; k < 100 && ledOn !== 6'h00; k++) cyc(1);
    bound(k < 100);
  endtask : t_led

  // a short press is refused, a five second hold connects
  task automatic t_conn();
    cfgConnReq = 1'b1;
    cyc(1);
    cfgConnReq = 1'b0;
    testButtonN = 1'b0;
    cyc(1000 * TICK);
    testButtonN = 1'b1;
    cyc(20);
    chk(cfgConnected, 1'h0);
    cfgConnReq = 1'b1;
    cyc(1);
    cfgConnReq = 1'b0;
    testButtonN = 1'b0;
    cyc(4900 * TICK);
    chk(cfgConnected, 1'h0);
    for (k = 0; k < 200 * TICK && cfgConnected !== 1'b1; k++) cyc(1);
    bound(k < 200 * TICK);
    testButtonN = 1'b1;
  endtask : t_conn

  // link loss and recovery with the default-state function off or on
  task automatic t_loss(input logic fs);
    int r0;
    cfgFsEn = fs;
    cfgLoad = 1'b1;
    cyc(1);
    cfgLoad = 1'b0;
    sawMis = 1'b0;
    peerInN = 2'h2;
    cyc(4);
    chk(relayOut, 2'h1);
    chk(sawMis, 1'h1);
    kick = 1'b1;
    cyc(16);
    r0 = reqCount;
    cyc(200);
    chk(reqCount, r0);
    silent = 1'b1;
    for (k = 0; k < 20 && exchangeOk !== 1'b1; k++) cyc(1);
    bound(k < 20);
    kick = 1'b0;
    r0 = reqCount;
    cyc(12);
    chk(reqCount, r0);
    for (k = 0; k < 24 && reqCount == r0; k++) cyc(1);
    bound(k < 24);
    for (k = 0; k < 200 && missCount !== 8'h02; k++) cyc(1);
    bound(k < 200);
    cyc(2);
    chk({retrying, commLost}, 2'h2);
    chk(relayOut, fs ? 2'h0 : 2'h1);
    for (k = 0; k < 40 && missCount !== 8'h03; k++) cyc(1);
    bound(k < 40);
    cyc(42);
    chk(commLost, 1'h1);
    chk(relayOut, fs ? 2'h2 : 2'h1);
    kick = 1'b1;
    for (k = 0; k < 20 && missCount !== 8'h00; k++) cyc(1);
    bound(k < 20);
    cyc(1);
    chk({retrying, commLost, relayOut}, fs ? 4'h2 : 4'h1);
    kick = 1'b0;
    silent = 1'b0;
  endtask : t_loss

  // slow check reply that finds a disagreeing output
  task automatic t_check();
    int r0;
    silent = 1'b1;
    peerInN = 2'h1;
    cyc(2);
    silent = 1'b0;
    answerDelay = 8'h1E;
    sawMis = 1'b0;
    r0 = reqCount;
    for (k = 0; k < 40 && reqCount == r0; k++) cyc(1);
    bound(k < 40);
    for (k = 0; k < 60 && relayOut !== 2'h2; k++) cyc(1);
    bound(k < 60);
    cyc(2);
    chk({sawMis, missCount}, 9'h100);
    answerDelay = 8'h02;
  endtask : t_check

  // indicators switched off stay dark on a new reading
  task automatic t_ledOff();
    cfgLedEn = 1'b0;
    cfgLoad = 1'b1;
    cyc(1);
    cfgLoad = 1'b0;
    rssiLevel = 3'h5;
    rssiValid = 1'b1;
    cyc(1);
    rssiValid = 1'b0;
    cyc(1);
    chk(ledOn, 6'h00);
  endtask : t_ledOff

  // main sequence
  initial
  begin
    {reset_n, cfgConnReq, cfgDisconnect, cfgLoad, rssiValid, silent, kick} = '0;
    {testButtonN, cfgLedEn, cfgFsEn, peerInN, rssiLevel} = {3'h6, 2'h3, 3'h0};
    {cfgHbMs, cfgMissLimit, cfgLedMs} = {16'h0005, 8'h03, 16'h03E8};
    {cfgDefault, cfgAlertEn, cfgTimeoutMult} = {2'h2, 2'h2, 8'h01, 8'h02};
    {answerDelay, err_count, compares, reqCount, sawMis} = '0;
    answerDelay = 8'h02;
    cyc(5);
    chk({relayOut, ledOn, cfgConnected, retrying, commLost, missCount}, 32'h0);
    reset_n = 1'b1;
    t_led();
    t_conn();
    t_loss(1'b0);
    t_check();
    t_loss(1'b1);
    t_ledOff();
    cfgDisconnect = 1'b1;
    cyc(1);
    cfgDisconnect = 1'b0;
    cyc(2);
    chk(cfgConnected, 1'h0);
    summarize();
  end
endmodule : lhf_link_failsafe_test
